// *** common/aer_defs.svh ***
// register offsets, field layout, reset values and implemented-bit masks of the error bank
`ifndef AER_DEFS_SVH
`define AER_DEFS_SVH

// byte addresses within configuration space
`define AER_OFS_HEADER 12'h100
`define AER_OFS_UNC_FLAGS 12'h104
`define AER_OFS_UNC_MASKS 12'h108
`define AER_OFS_UNC_SEVS 12'h10c
`define AER_OFS_COR_FLAGS 12'h110
`define AER_OFS_COR_MASKS 12'h114

// first dword fields
`define AER_CAP_ID_LSB 0
`define AER_CAP_ID_VAL 16'h0001
`define AER_VERSION_LSB 16
`define AER_VERSION_VAL 4'h1
`define AER_NEXT_PTR_LSB 20
`define AER_NEXT_PTR_VAL 12'h150

// implemented bits; everything else reads zero and ignores writes
`define AER_UNC_IMPL 32'h001f_f011
`define AER_COR_IMPL 32'h0000_31c1

// reset values
`define AER_UNC_FLAGS_RST 32'h0000_0000
`define AER_UNC_MASKS_RST 32'h0000_0000
`define AER_UNC_SEVS_RST 32'h0006_2011
`define AER_COR_FLAGS_RST 32'h0000_0000
`define AER_COR_MASKS_RST 32'h0000_2000

`endif

// *** common/aer_pkg.sv ***
// types and shared decode helpers for the error register bank
`include "aer_defs.svh"
package aer_pkg;
  typedef enum logic [2:0] {
    SEL_HEADER = 3'b000,
    SEL_UNC_FLAGS = 3'b001,
    SEL_UNC_MASKS = 3'b010,
    SEL_UNC_SEVS = 3'b011,
    SEL_COR_FLAGS = 3'b100,
    SEL_COR_MASKS = 3'b101,
    SEL_NONE = 3'b110
  } reg_sel_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } apb_state_e;

  function automatic reg_sel_e reg_decode(input logic [11:0] addr);
    case (addr)
      `AER_OFS_HEADER: reg_decode = SEL_HEADER;
      `AER_OFS_UNC_FLAGS: reg_decode = SEL_UNC_FLAGS;
      `AER_OFS_UNC_MASKS: reg_decode = SEL_UNC_MASKS;
      `AER_OFS_UNC_SEVS: reg_decode = SEL_UNC_SEVS;
      `AER_OFS_COR_FLAGS: reg_decode = SEL_COR_FLAGS;
      `AER_OFS_COR_MASKS: reg_decode = SEL_COR_MASKS;
      default: reg_decode = SEL_NONE;
    endcase
  endfunction : reg_decode
endpackage : aer_pkg

// *** common/aer_bus_if.sv ***
// decoded register access passed from the bus slave to the register bank
`timescale 1ns/1ps
interface aer_bus_if;
  logic wr_stb;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [3:0] strb;
  logic [31:0] rdata;
  logic rd_err;

  modport slave (
    output wr_stb, addr, wdata, strb,
    input rdata, rd_err
  );
  modport bank (
    input wr_stb, addr, wdata, strb,
    output rdata, rd_err
  );
endinterface : aer_bus_if

// *** rtl/aer_sticky_word.sv ***
// one 32-bit sticky word, either read-write or write-one-to-clear with hardware set
`timescale 1ns/1ps
module aer_sticky_word #(
  parameter logic [31:0] IMPL = 32'hffff_ffff,
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter bit W1C = 1'b0
) (
  input wire logic clk_i,
  input wire logic por_b_i,
  input wire logic [31:0] set_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] wmask_i,
  output logic [31:0] q_o
);
  logic [31:0] next_q;
  logic [31:0] hit;

  always_comb begin
    hit = wr_i ? (wdata_i & wmask_i) : 32'h0000_0000;
    if (W1C) begin
      // set after clear, so an event in the clearing cycle survives
      next_q = ((q_o & ~hit) | set_i) & IMPL;
    end else begin
      next_q = ((q_o & ~(wr_i ? wmask_i : 32'h0000_0000)) | hit) & IMPL;
    end
  end

  // only power-on reset reaches this word
  always_ff @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      q_o <= RST_VAL;
    end else begin
      q_o <= next_q;
    end
  end
endmodule : aer_sticky_word

// *** rtl/aer_apb_slave.sv ***
// apb slave front end: one registered answer per transfer, no wait states in access
`timescale 1ns/1ps
module aer_apb_slave
  import aer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic warm_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  aer_bus_if.slave bus
);
  apb_state_e state, next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  assign bus.addr = paddr_i;
  assign bus.wdata = pwdata_i;
  assign bus.strb = pstrb_i;
  // the write lands at the one edge where the master samples pready high
  assign bus.wr_stb = (state == ST_ACK) & psel_i & penable_i & pwrite_i & ~bus.rd_err;

  always_comb begin
    next_state = state;
    next_prdata = prdata_o;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (psel_i && !penable_i) begin
          next_state = ST_ACK;
          next_pready = 1'b1;
          next_pslverr = bus.rd_err;
          next_prdata = (pwrite_i || bus.rd_err) ? 32'h0000_0000 : bus.rdata;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
    endcase
    if (warm_rst_i) begin
      next_state = ST_IDLE;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      state <= next_state;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end
endmodule : aer_apb_slave

// *** rtl/aer_error_register_bank.sv ***
// error reporting capability register bank with apb access and error reporting outputs
//
// Behaviour
// - the first dword reads a fixed capability identifier of 0001h in bits 15:0.
// - bits 19:16 of the first dword read a fixed version of 1h and ignore writes.
// - bits 31:20 of the first dword read a fixed next pointer of 150h.
// - uncorrectable flags at 104h bits 0, 4, 12..20 are sticky, write-one-clear, reset 0.
// - uncorrectable masks at 108h hold one sticky read-write bit per flag, reset 0.
// - uncorrectable severities at 10Ch reset to 1 in bits 0, 4, 13, 17, 18, else 0.
// - correctable flags at 110h bits 0, 6, 7, 8, 12, 13 are sticky, write-one-clear.
// - correctable masks at 114h hold one sticky read-write bit per correctable flag.
// - correctable_error_masks bit 13 for advisory non-fatal errors resets to 1.
`timescale 1ns/1ps
`include "aer_defs.svh"
module aer_error_register_bank
  import aer_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic WARM_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [31:0] COR_ERR_I,
  output logic FATAL_MSG_O,
  output logic NONFATAL_MSG_O,
  output logic COR_MSG_O,
  output logic UNC_PENDING_O,
  output logic COR_PENDING_O
);

  // ----------------------------------------------------------------
  // local helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  aer_bus_if bus ();

  aer_apb_slave u_apb (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .warm_rst_i(WARM_RST_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .pstrb_i(PSTRB_I),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .bus(bus.slave)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  reg_sel_e wr_sel;
  logic [31:0] wmask;
  logic wr_unc_flags;
  logic wr_unc_masks;
  logic wr_unc_sevs;
  logic wr_cor_flags;
  logic wr_cor_masks;

  assign wr_sel = reg_decode(bus.addr);
  assign wmask = lane_mask(bus.strb);
  assign wr_unc_flags = bus.wr_stb & (wr_sel == SEL_UNC_FLAGS);
  assign wr_unc_masks = bus.wr_stb & (wr_sel == SEL_UNC_MASKS);
  assign wr_unc_sevs = bus.wr_stb & (wr_sel == SEL_UNC_SEVS);
  assign wr_cor_flags = bus.wr_stb & (wr_sel == SEL_COR_FLAGS);
  assign wr_cor_masks = bus.wr_stb & (wr_sel == SEL_COR_MASKS);

  // ----------------------------------------------------------------
  // error events
  // ----------------------------------------------------------------
  // detectors run on this clock, so no synchroniser; unused bits are dropped here
  logic [31:0] unc_evt;
  logic [31:0] cor_evt;

  assign unc_evt = UNC_ERR_I & `AER_UNC_IMPL;
  assign cor_evt = COR_ERR_I & `AER_COR_IMPL;

  // ----------------------------------------------------------------
  // sticky registers
  // ----------------------------------------------------------------
  // tied to the power-on reset only; warm reset leaves them alone
  logic [31:0] unc_flags;
  logic [31:0] unc_masks;
  logic [31:0] unc_sevs;
  logic [31:0] cor_flags;
  logic [31:0] cor_masks;

  aer_sticky_word #(
    .IMPL(`AER_UNC_IMPL),
    .RST_VAL(`AER_UNC_FLAGS_RST),
    .W1C(1'b1)
  ) u_unc_flags (
    .clk_i(SYS_CLK_I),
    .por_b_i(RST_B_I),
    .set_i(unc_evt),
    .wr_i(wr_unc_flags),
    .wdata_i(bus.wdata),
    .wmask_i(wmask),
    .q_o(unc_flags)
  );

  aer_sticky_word #(
    .IMPL(`AER_UNC_IMPL),
    .RST_VAL(`AER_UNC_MASKS_RST),
    .W1C(1'b0)
  ) u_unc_masks (
    .clk_i(SYS_CLK_I),
    .por_b_i(RST_B_I),
    .set_i(32'h0000_0000),
    .wr_i(wr_unc_masks),
    .wdata_i(bus.wdata),
    .wmask_i(wmask),
    .q_o(unc_masks)
  );

  aer_sticky_word #(
    .IMPL(`AER_UNC_IMPL),
    .RST_VAL(`AER_UNC_SEVS_RST),
    .W1C(1'b0)
  ) u_unc_sevs (
    .clk_i(SYS_CLK_I),
    .por_b_i(RST_B_I),
    .set_i(32'h0000_0000),
    .wr_i(wr_unc_sevs),
    .wdata_i(bus.wdata),
    .wmask_i(wmask),
    .q_o(unc_sevs)
  );

  aer_sticky_word #(
    .IMPL(`AER_COR_IMPL),
    .RST_VAL(`AER_COR_FLAGS_RST),
    .W1C(1'b1)
  ) u_cor_flags (
    .clk_i(SYS_CLK_I),
    .por_b_i(RST_B_I),
    .set_i(cor_evt),
    .wr_i(wr_cor_flags),
    .wdata_i(bus.wdata),
    .wmask_i(wmask),
    .q_o(cor_flags)
  );

  aer_sticky_word #(
    .IMPL(`AER_COR_IMPL),
    .RST_VAL(`AER_COR_MASKS_RST),
    .W1C(1'b0)
  ) u_cor_masks (
    .clk_i(SYS_CLK_I),
    .por_b_i(RST_B_I),
    .set_i(32'h0000_0000),
    .wr_i(wr_cor_masks),
    .wdata_i(bus.wdata),
    .wmask_i(wmask),
    .q_o(cor_masks)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg_sel_e rd_sel;
  logic [31:0] header_word;

  assign rd_sel = reg_decode(bus.addr);

  always_comb begin
    header_word = 32'h0000_0000;
    header_word[`AER_CAP_ID_LSB +: 16] = `AER_CAP_ID_VAL;
    header_word[`AER_VERSION_LSB +: 4] = `AER_VERSION_VAL;
    header_word[`AER_NEXT_PTR_LSB +: 12] = `AER_NEXT_PTR_VAL;
  end

  always_comb begin
    bus.rd_err = 1'b0;
    unique case (rd_sel)
      SEL_HEADER: bus.rdata = header_word;
      SEL_UNC_FLAGS: bus.rdata = unc_flags;
      SEL_UNC_MASKS: bus.rdata = unc_masks;
      SEL_UNC_SEVS: bus.rdata = unc_sevs;
      SEL_COR_FLAGS: bus.rdata = cor_flags;
      SEL_COR_MASKS: bus.rdata = cor_masks;
      default: begin
        // outside the map or misaligned: error answer, no effect
        bus.rdata = 32'h0000_0000;
        bus.rd_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // error reporting
  // ----------------------------------------------------------------
  // masks gate only the message, never the flag; severity picks the class
  logic [31:0] unc_report;
  logic [31:0] cor_report;
  logic next_fatal;
  logic next_nonfatal;
  logic next_cor;
  logic next_unc_pending;
  logic next_cor_pending;

  always_comb begin
    unc_report = unc_evt & ~unc_masks;
    cor_report = cor_evt & ~cor_masks;
    next_fatal = |(unc_report & unc_sevs);
    next_nonfatal = |(unc_report & ~unc_sevs);
    next_cor = |cor_report;
    next_unc_pending = |unc_flags;
    next_cor_pending = |cor_flags;
    if (WARM_RST_I) begin
      // messages are not sent while the port is held in reset
      next_fatal = 1'b0;
      next_nonfatal = 1'b0;
      next_cor = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FATAL_MSG_O <= 1'b0;
      NONFATAL_MSG_O <= 1'b0;
      COR_MSG_O <= 1'b0;
      UNC_PENDING_O <= 1'b0;
      COR_PENDING_O <= 1'b0;
    end else begin
      FATAL_MSG_O <= next_fatal;
      NONFATAL_MSG_O <= next_nonfatal;
      COR_MSG_O <= next_cor;
      UNC_PENDING_O <= next_unc_pending;
      COR_PENDING_O <= next_cor_pending;
    end
  end

endmodule : aer_error_register_bank

// *** verif/aer_bank_sva.sv ***
// port-level checker for the error register bank
`timescale 1ns/1ps
module aer_bank_sva (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic WARM_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [31:0] COR_ERR_I,
  input wire logic FATAL_MSG_O,
  input wire logic NONFATAL_MSG_O,
  input wire logic COR_MSG_O,
  input wire logic UNC_PENDING_O,
  input wire logic COR_PENDING_O
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic unc_ev;
  logic cor_ev;
  assign unc_ev = |(UNC_ERR_I & 32'h001f_f011);
  assign cor_ev = |(COR_ERR_I & 32'h0000_31c1);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_rd(a);
    PSEL_I && !PENABLE_I && !PWRITE_I && !WARM_RST_I && PADDR_I == a;
  endsequence
  sequence s_any;
    PSEL_I && !PENABLE_I && !WARM_RST_I;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_hdr;
    s_rd(12'h100) |=> PREADY_O && PRDATA_O == 32'h1501_0001;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header word wrong");
  property p_unc_rsv;
    s_rd(12'h104) |=> (PRDATA_O & 32'hffe0_0fee) == 32'h0000_0000;
  endproperty
  a_unc_rsv: assert property (p_unc_rsv) else $error("reserved flag bit set");
  property p_cor_rsv;
    s_rd(12'h110) |=> (PRDATA_O & 32'hffff_ce3e) == 32'h0000_0000;
  endproperty
  a_cor_rsv: assert property (p_cor_rsv) else $error("reserved flag bit set");
  property p_unc_pend;
    unc_ev |-> ##2 UNC_PENDING_O;
  endproperty
  a_unc_pend: assert property (p_unc_pend) else $error("event lost");
  property p_cor_pend;
    cor_ev |-> ##2 COR_PENDING_O;
  endproperty
  a_cor_pend: assert property (p_cor_pend) else $error("event lost");
  property p_unc_msg;
    FATAL_MSG_O || NONFATAL_MSG_O |-> $past(unc_ev);
  endproperty
  a_unc_msg: assert property (p_unc_msg) else $error("message without event");
  property p_cor_msg;
    COR_MSG_O |-> $past(cor_ev);
  endproperty
  a_cor_msg: assert property (p_cor_msg) else $error("message without event");
  property p_unmapped;
    s_any ##0 !(PADDR_I inside {12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114})
      |=> PREADY_O && PSLVERR_O;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule : aer_bank_sva

bind aer_error_register_bank aer_bank_sva u_sva (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
  .WARM_RST_I(WARM_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .UNC_ERR_I(UNC_ERR_I), .COR_ERR_I(COR_ERR_I), .FATAL_MSG_O(FATAL_MSG_O),
  .NONFATAL_MSG_O(NONFATAL_MSG_O), .COR_MSG_O(COR_MSG_O), .UNC_PENDING_O(UNC_PENDING_O),
  .COR_PENDING_O(COR_PENDING_O));

// *** verif/testbench.sv ***
// self-checking bench for the error register bank
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals and tables
  // ----------------------------------------
  logic clk, rst_b, warm, psel, pen, pwr, pready, pslverr, fat, nfat, cmsg, upend, cpend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, unc, cor;
  logic [3:0] pstrb;
  int err_total, total_checks;
  logic [11:0] ofs [6] = '{12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114};
  logic [31:0] rstv [6] = '{32'h1501_0001, 32'h0, 32'h0, 32'h0006_2011, 32'h0, 32'h0000_2000};
  logic [31:0] impl [6] = '{32'h1501_0001, 32'h0, 32'h001f_f011, 32'h001f_f011, 32'h0,
                            32'h0000_31c1};
  logic [31:0] eu [5] = '{32'h1, 32'h0000_1000, 32'h0, 32'h0, 32'h2};
  logic [31:0] ec [5] = '{32'h0, 32'h0, 32'h1, 32'h0000_2000, 32'h2};
  logic [2:0] em [5] = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b000};
  aer_error_register_bank dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .WARM_RST_I(warm),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .UNC_ERR_I(unc), .COR_ERR_I(cor), .FATAL_MSG_O(fat), .NONFATAL_MSG_O(nfat),
    .COR_MSG_O(cmsg), .UNC_PENDING_O(upend), .COR_PENDING_O(cpend));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle cycle follows so strobes never toggle twice at one edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic xe);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
    if (!w) chk(prdata, d);
    chk({31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [2:0] xm);
    unc <= u;
    cor <= c;
    @(posedge clk);
    unc <= 32'h0;
    cor <= 32'h0;
    @(posedge clk);
    chk({29'h0, fat, nfat, cmsg}, {29'h0, xm});
  endtask : ev
  task automatic chk_rst();
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, ofs[i], rstv[i], 4'h0, 1'b0);
    end
    $display("test reset values done");
  endtask : chk_rst
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    warm = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    unc = 32'h0;
    cor = 32'h0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk_rst();
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, ofs[i], 32'hffff_ffff, 4'hf, 1'b0);
      acc(1'b0, ofs[i], impl[i], 4'h0, 1'b0);
    end
    acc(1'b1, 12'h108, 32'h0, 4'h1, 1'b0);
    acc(1'b0, 12'h108, 32'h001f_f000, 4'h0, 1'b0);
    acc(1'b1, 12'h108, 32'h0, 4'hf, 1'b0);
    acc(1'b1, 12'h10c, 32'h0006_2011, 4'hf, 1'b0);
    acc(1'b1, 12'h114, 32'h0000_2000, 4'hf, 1'b0);
    $display("test write access done");
    for (int i = 0; i < 5; i++) begin
      ev(eu[i], ec[i], em[i]);
    end
    acc(1'b0, 12'h104, 32'h0000_1001, 4'h0, 1'b0);
    acc(1'b0, 12'h110, 32'h0000_2001, 4'h0, 1'b0);
    chk({30'h0, upend, cpend}, 32'h0000_0003);
    $display("test events done");
    ev(32'hffff_ffff, 32'hffff_ffff, 3'b111);
    acc(1'b1, 12'h104, 32'h0000_1001, 4'h1, 1'b0);
    acc(1'b0, 12'h104, 32'h001f_f010, 4'h0, 1'b0);
    acc(1'b1, 12'h110, 32'hffff_ffff, 4'h2, 1'b0);
    acc(1'b0, 12'h110, 32'h0000_00c1, 4'h0, 1'b0);
    $display("test clear done");
    acc(1'b1, 12'h108, 32'h0000_0010, 4'hf, 1'b0);
    warm <= 1'b1;
    // flags still record events under warm reset, but no message goes out
    ev(32'h0000_0001, 32'h0000_0001, 3'b000);
    warm <= 1'b0;
    @(posedge clk);
    acc(1'b0, 12'h104, 32'h001f_f011, 4'h0, 1'b0);
    acc(1'b0, 12'h108, 32'h0000_0010, 4'h0, 1'b0);
    $display("test warm reset done");
    acc(1'b0, 12'h118, 32'h0, 4'h0, 1'b1);
    acc(1'b1, 12'h102, 32'hffff_ffff, 4'hf, 1'b1);
    $display("test unmapped done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk_rst();
    chk({30'h0, upend, cpend}, 32'h0000_0000);
    end_of_test();
  end
endmodule : testbench
